// >>> hdl/ccs_pkg.sv
/*
 * Constants for the CPU clock select control block: register addresses,
 * field positions, writable masks, reset values and divider figures.
 * Assumes an 8-bit CPU with a 16-bit special-function-register space.
 */
package ccs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register addresses in the CPU memory map
	localparam logic [15:0] CCS_ADDR_SUBOSC_MODE = 16'hFFF0;
	localparam logic [15:0] CCS_ADDR_SUBCLOCK_SELECT = 16'hFFF2;
	localparam logic [15:0] CCS_ADDR_PROC_CLK_CTRL = 16'hFFFB;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] CCS_RST_PROC_CLK_CTRL = 8'h02;
	localparam logic [7:0] CCS_RST_SUBOSC_MODE = 8'h00;
	localparam logic [7:0] CCS_RST_SUBCLOCK_SELECT = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CCS_MAIN_OSC_STOP_BIT = 7;
	localparam int CCS_CPU_DIV_SELECT_BIT = 1;
	localparam int CCS_FB_RES_DISABLE_BIT = 1;
	localparam int CCS_SUB_OSC_STOP_BIT = 0;
	localparam int CCS_CLOCK_SOURCE_STATUS_BIT = 5;
	localparam int CCS_SUB_SELECT_BIT = 4;

	// Bits that software may change; the rest are stored as zero
	localparam logic [7:0] CCS_WMASK_PROC_CLK_CTRL = 8'h82;
	localparam logic [7:0] CCS_WMASK_SUBOSC_MODE = 8'h03;
	localparam logic [7:0] CCS_WMASK_SUBCLOCK_SELECT = 8'h10;

	////////////////////////////////////////////////////////////////////////////
	// Dividers and oscillation stabilization
	localparam logic [1:0] CCS_MAIN_DIV_LAST = 2'h3;
	localparam int CCS_STAB_LOG2 = 15;
	localparam int CCS_STAB_TICKS = 2 ** CCS_STAB_LOG2;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		CCS_SRC_MAIN_FULL,
		CCS_SRC_MAIN_DIV4,
		CCS_SRC_SUB_HALF
	} ccs_src_e;

	typedef enum logic {
		CCS_ST_STAB,
		CCS_ST_RUN
	} ccs_state_e;

endpackage

// >>> hdl/ccs_clock_ctrl.sv
/*
 * CPU clock select control: three byte-wide control registers written by
 * CPU memory instructions (byte or single-bit), oscillator enables, the
 * CPU, peripheral and watch clock enables, and the post-reset wait.
 * Assumes main_osc_tick and sub_osc_tick are one-cycle enables made on
 * core_clk by the oscillator front end, and stop_mode comes from the CPU
 * on the same clock, so none of them is synchronised here.
 */
`timescale 1ns/1ps

module ccs_clock_ctrl
	import ccs_pkg::*;
#(
	parameter int STAB_TICKS = CCS_STAB_TICKS
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_bit_wr,
	input wire logic [2:0] cpu_bit_idx,
	input wire logic cpu_bit_val,
	input wire logic cpu_rd,
	output logic [7:0] cpu_rdata,
	output logic cpu_rd_valid,
	input wire logic stop_mode,
	input wire logic main_osc_tick,
	input wire logic sub_osc_tick,
	output logic main_osc_en,
	output logic sub_osc_en,
	output logic fb_res_en,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic watch_clk_en,
	output logic cpu_run,
	output logic cpu_on_sub
);

	localparam int STAB_W = $clog2(STAB_TICKS + 1);
	localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB_TICKS - 1);

	if (STAB_TICKS < 1) begin : g_bad_stab
		$error("STAB_TICKS must be at least one");
	end

	////////////////////////////////////////////////////////////////////////////
	// Register storage and state
	logic [7:0] pclk_q;
	logic [7:0] pclk_d;
	logic [7:0] subm_q;
	logic [7:0] subm_d;
	logic [7:0] csel_q;
	logic [7:0] csel_d;
	ccs_src_e src_q;
	ccs_src_e src_d;
	ccs_state_e state_q;
	ccs_state_e state_d;
	logic [STAB_W-1:0] stab_cnt_q;
	logic [STAB_W-1:0] stab_cnt_d;
	logic [1:0] div_cnt_q;
	logic [1:0] div_cnt_d;
	logic sub_ph_q;
	logic sub_ph_d;
	logic [7:0] rdata_d;

	////////////////////////////////////////////////////////////////////////////
	// Address decode and write data
	wire logic hit_pclk = (cpu_addr == CCS_ADDR_PROC_CLK_CTRL);
	wire logic hit_subm = (cpu_addr == CCS_ADDR_SUBOSC_MODE);
	wire logic hit_csel = (cpu_addr == CCS_ADDR_SUBCLOCK_SELECT);
	wire logic wr_any = cpu_wr | cpu_bit_wr;
	wire logic [7:0] bit_mask = 8'h01 << cpu_bit_idx;

	// One write enable per register keeps the next-value muxes plain
	wire logic pclk_we = wr_any & hit_pclk;
	wire logic subm_we = wr_any & hit_subm;
	wire logic csel_we = wr_any & hit_csel;

	// Status is composed live so that software reads the actual source
	wire logic status_now = (src_q == CCS_SRC_SUB_HALF);
	wire logic [7:0] status_img = {7'h00, status_now} << CCS_CLOCK_SOURCE_STATUS_BIT;
	wire logic [7:0] csel_view = csel_q | status_img;

	// A bit write is a read-modify-write of the current image
	wire logic [7:0] pclk_set = pclk_q | bit_mask;
	wire logic [7:0] pclk_clr = pclk_q & ~bit_mask;
	wire logic [7:0] subm_set = subm_q | bit_mask;
	wire logic [7:0] subm_clr = subm_q & ~bit_mask;
	wire logic [7:0] csel_set = csel_view | bit_mask;
	wire logic [7:0] csel_clr = csel_view & ~bit_mask;
	wire logic [7:0] pclk_bit = cpu_bit_val ? pclk_set : pclk_clr;
	wire logic [7:0] subm_bit = cpu_bit_val ? subm_set : subm_clr;
	wire logic [7:0] csel_bit = cpu_bit_val ? csel_set : csel_clr;
	wire logic [7:0] pclk_wval = cpu_bit_wr ? pclk_bit : cpu_wdata;
	wire logic [7:0] subm_wval = cpu_bit_wr ? subm_bit : cpu_wdata;
	wire logic [7:0] csel_wval = cpu_bit_wr ? csel_bit : cpu_wdata;

	// Masking keeps reserved bits at zero even if software ignores them
	assign pclk_d = pclk_we ? (pclk_wval & CCS_WMASK_PROC_CLK_CTRL) : pclk_q;
	assign subm_d = subm_we ? (subm_wval & CCS_WMASK_SUBOSC_MODE) : subm_q;
	// The status bit is outside the write mask, so writes cannot touch it
	assign csel_d = csel_we ? (csel_wval & CCS_WMASK_SUBCLOCK_SELECT) : csel_q;

	assign rdata_d = hit_pclk ? pclk_q :
		hit_subm ? subm_q :
		hit_csel ? csel_view :
		8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Oscillator controls
	wire logic main_stop_bit = pclk_q[CCS_MAIN_OSC_STOP_BIT];
	wire logic cpu_div_select = pclk_q[CCS_CPU_DIV_SELECT_BIT];
	wire logic sub_osc_stop = subm_q[CCS_SUB_OSC_STOP_BIT];
	wire logic fb_res_disable = subm_q[CCS_FB_RES_DISABLE_BIT];
	wire logic sub_select = csel_q[CCS_SUB_SELECT_BIT];

	// Software is trusted to set main_osc_stop only when on the subclock
	wire logic main_en_d = ~main_stop_bit & ~stop_mode;
	// The STOP instruction leaves the subsystem oscillator alone
	wire logic sub_en_d = ~sub_osc_stop;
	wire logic fb_en_d = ~fb_res_disable;

	wire logic main_tick_ok = main_osc_tick & main_osc_en;
	wire logic sub_tick_ok = sub_osc_tick & sub_osc_en;

	////////////////////////////////////////////////////////////////////////////
	// CPU clock source selection
	wire ccs_src_e req_src = sub_select ? CCS_SRC_SUB_HALF :
		(cpu_div_select ? CCS_SRC_MAIN_DIV4 : CCS_SRC_MAIN_FULL);

	wire logic pulse_full = main_tick_ok;
	wire logic pulse_div4 = main_tick_ok & (div_cnt_q == CCS_MAIN_DIV_LAST);
	wire logic pulse_half = sub_tick_ok & sub_ph_q;

	wire logic cur_pulse = (src_q == CCS_SRC_SUB_HALF) ? pulse_half :
		(src_q == CCS_SRC_MAIN_DIV4) ? pulse_div4 :
		pulse_full;

	// A dead source gives no pulses, so leaving it cannot glitch either
	wire logic old_alive = (src_q == CCS_SRC_SUB_HALF) ? sub_osc_en : main_osc_en;
	wire logic switch_now = (req_src != src_q) & (cur_pulse | ~old_alive);

	assign src_d = switch_now ? req_src : src_q;

	// Dividers restart on a switch so the first new period is full length
	assign div_cnt_d = switch_now ? 2'h0 :
		(main_tick_ok ? div_cnt_q + 2'h1 : div_cnt_q);
	assign sub_ph_d = switch_now ? 1'b0 :
		(sub_tick_ok ? ~sub_ph_q : sub_ph_q);

	////////////////////////////////////////////////////////////////////////////
	// Oscillation stabilization after reset
	always_comb begin
		state_d = state_q;
		stab_cnt_d = stab_cnt_q;
		case (state_q)
			CCS_ST_STAB: begin
				if (main_tick_ok) begin
					if (stab_cnt_q == STAB_LAST) begin
						state_d = CCS_ST_RUN;
					end else begin
						stab_cnt_d = stab_cnt_q + STAB_W'(1);
					end
				end
			end
			CCS_ST_RUN: begin
				stab_cnt_d = stab_cnt_q;
			end
			default: begin
				state_d = CCS_ST_STAB;
				stab_cnt_d = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pclk_q <= CCS_RST_PROC_CLK_CTRL;
		end else begin
			pclk_q <= pclk_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			subm_q <= CCS_RST_SUBOSC_MODE;
		end else begin
			subm_q <= subm_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			csel_q <= CCS_RST_SUBCLOCK_SELECT;
		end else begin
			csel_q <= csel_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			src_q <= CCS_SRC_MAIN_DIV4;
			div_cnt_q <= 2'h0;
			sub_ph_q <= 1'b0;
		end else begin
			src_q <= src_d;
			div_cnt_q <= div_cnt_d;
			sub_ph_q <= sub_ph_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= CCS_ST_STAB;
			stab_cnt_q <= '0;
		end else begin
			state_q <= state_d;
			stab_cnt_q <= stab_cnt_d;
		end
	end

	// Main oscillator stays off through reset
	// Limitation: no settling wait follows a restart; software must time it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			main_osc_en <= 1'b0;
		end else begin
			main_osc_en <= main_en_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sub_osc_en <= 1'b1;
			fb_res_en <= 1'b1;
		end else begin
			sub_osc_en <= sub_en_d;
			fb_res_en <= fb_en_d;
		end
	end

	// Clock enables; the CPU sees none until stabilization is over
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cpu_clk_en <= 1'b0;
			cpu_run <= 1'b0;
			cpu_on_sub <= 1'b0;
		end else begin
			cpu_clk_en <= cur_pulse & (state_q == CCS_ST_RUN);
			cpu_run <= (state_d == CCS_ST_RUN);
			cpu_on_sub <= (src_d == CCS_SRC_SUB_HALF);
		end
	end

	// Peripherals run from the main oscillator only, the watch clock from sub
	always_ff @(posedge core_clk) begin
		if (rst) begin
			periph_clk_en <= 1'b0;
			watch_clk_en <= 1'b0;
		end else begin
			periph_clk_en <= main_tick_ok;
			watch_clk_en <= sub_tick_ok;
		end
	end

	// Read port
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cpu_rdata <= 8'h00;
			cpu_rd_valid <= 1'b0;
		end else begin
			cpu_rdata <= cpu_rd ? rdata_d : cpu_rdata;
			cpu_rd_valid <= cpu_rd;
		end
	end

endmodule

// >>> bench/ccs_props.sv
/* Port assertions for the CPU clock select block.
   Assumes single-cycle strobes and a synchronous active-high reset. */
`timescale 1ns/1ps
module ccs_props
	import ccs_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_wr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_rd,
	input wire logic [7:0] cpu_rdata,
	input wire logic cpu_rd_valid,
	input wire logic stop_mode,
	input wire logic sub_osc_tick,
	input wire logic main_osc_en,
	input wire logic sub_osc_en,
	input wire logic fb_res_en,
	input wire logic cpu_clk_en,
	input wire logic cpu_run,
	input wire logic cpu_on_sub
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire is_subm = cpu_addr == CCS_ADDR_SUBOSC_MODE;
	wire is_pclk = cpu_addr == CCS_ADDR_PROC_CLK_CTRL;
	wire wr_subm = cpu_wr && is_subm;
	wire wr_pclk = cpu_wr && is_pclk;
	wire is_csel = cpu_addr == CCS_ADDR_SUBCLOCK_SELECT;
	wire mapped = is_csel || is_subm || is_pclk;
	sequence rd_csel;
		cpu_rd && is_csel;
	endsequence
	sequence on_sub_steady;
		cpu_on_sub && $past(cpu_on_sub, 2);
	endsequence
	////////////////////////////////////////////////////////////////
	a_read_answer: assert property (cpu_rd |=> cpu_rd_valid)
		else $error("read not answered");
	a_stop_instr: assert property (stop_mode |=> !main_osc_en)
		else $error("stop did not halt main oscillator");
	a_main_stop_bit: assert property (wr_pclk && cpu_wdata[7] |-> ##2 !main_osc_en)
		else $error("main_osc_stop ignored");
	a_sub_stop: assert property (wr_subm && cpu_wdata[0] |-> ##2 !sub_osc_en)
		else $error("sub_osc_stop ignored");
	a_fb_res: assert property (wr_subm && cpu_wdata[1] |-> ##2 !fb_res_en)
		else $error("fb_res_disable ignored");
	a_status_read: assert property (rd_csel |=> cpu_rdata == {2'h0, $past(cpu_on_sub), 5'h0}
		|| cpu_rdata == {2'h0, $past(cpu_on_sub), 5'h10}) else $error("status read wrong");
	a_unmapped_zero: assert property (cpu_rd && !mapped |=> cpu_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_run_gate: assert property (!cpu_run |-> !cpu_clk_en)
		else $error("cpu clock before stabilization");
	a_sub_clock: assert property (cpu_clk_en ##0 on_sub_steady |-> $past(sub_osc_tick))
		else $error("sub clock pulse without sub tick");
endmodule
bind ccs_clock_ctrl ccs_props u_props (.core_clk, .rst, .cpu_addr, .cpu_wr, .cpu_wdata, .cpu_rd,
	.cpu_rdata, .cpu_rd_valid, .stop_mode, .sub_osc_tick, .main_osc_en, .sub_osc_en, .fb_res_en,
	.cpu_clk_en, .cpu_run, .cpu_on_sub);

// >>> bench/cpu_clock_select_control_test.sv
/* Self-checking bench for ccs_clock_ctrl.
   Makes the oscillator ticks itself: main every 2 cycles, sub every 8. */
`timescale 1ns/1ps
module cpu_clock_select_control_test;
	import ccs_pkg::*;
	logic core_clk = 0, rst = 1, cpu_wr = 0, cpu_bit_wr = 0, cpu_bit_val = 0, cpu_rd = 0;
	logic stop_mode = 0, main_osc_tick = 0, sub_osc_tick = 0;
	logic [15:0] cpu_addr = 0;
	logic [7:0] cpu_wdata = 0;
	logic [2:0] cpu_bit_idx = 0, tc = 0;
	wire logic [7:0] cpu_rdata;
	wire logic rv, moe, soe, fbe, cce, pce, wce, run, onsub;
	int bad_count = 0, checked = 0, mt = 0;
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		tc <= rst ? 3'h0 : tc + 3'h1;
		main_osc_tick <= tc[0];
		sub_osc_tick <= tc == 3'h6;
		mt <= rst ? 0 : mt + int'(main_osc_tick && moe);
	end
	ccs_clock_ctrl #(.STAB_TICKS(8)) uut (.core_clk(core_clk), .rst(rst), .cpu_addr(cpu_addr),
		.cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_bit_wr(cpu_bit_wr), .cpu_bit_idx(cpu_bit_idx),
		.cpu_bit_val(cpu_bit_val), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_rd_valid(rv),
		.stop_mode(stop_mode), .main_osc_tick(main_osc_tick), .sub_osc_tick(sub_osc_tick),
		.main_osc_en(moe), .sub_osc_en(soe), .fb_res_en(fbe), .cpu_clk_en(cce),
		.periph_clk_en(pce), .watch_clk_en(wce), .cpu_run(run), .cpu_on_sub(onsub));
	////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// A bit write takes its value from d[0]
	task automatic wr(logic [15:0] a, logic [7:0] d, logic b = 0, logic [2:0] i = 0);
		@(posedge core_clk);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_wr <= !b;
		cpu_bit_wr <= b;
		cpu_bit_idx <= i;
		cpu_bit_val <= d[0];
		@(posedge core_clk);
		cpu_wr <= 0;
		cpu_bit_wr <= 0;
	endtask
	task automatic rd(logic [15:0] a, logic [7:0] e);
		@(posedge core_clk);
		cpu_addr <= a;
		cpu_rd <= 1;
		@(posedge core_clk);
		cpu_rd <= 0;
		#1;
		chk("rdata", cpu_rdata, e);
		chk("rd_valid", 8'(rv), 8'h01);
	endtask
	// Counts peripheral and watch clock pulses over 32 cycles
	task automatic clk_cnt(logic [7:0] ep, logic [7:0] ew);
		int np;
		int nw;
		np = 0;
		nw = 0;
		repeat (32) begin
			cyc(1);
			np += int'(pce);
			nw += int'(wce);
		end
		chk("periph_clk_en", 8'(np), ep);
		chk("watch_clk_en", 8'(nw), ew);
	endtask
	// Settles first so a switch in progress does not skew the period
	task automatic per(logic [7:0] e);
		int n;
		cyc(20);
		repeat (40) if (cce !== 1'b1) cyc(1);
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (cce !== 1'b1 && n < 40);
		chk("cpu_clk_period", 8'(n), e);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		repeat (100) if (mt < 7) cyc(1);
		chk("cpu_run", 8'(run), 8'h00);
		repeat (100) if (mt < 8) cyc(1);
		cyc(2);
		chk("cpu_run", 8'(run), 8'h01);
		clk_cnt(8'h10, 8'h04);
		rd(CCS_ADDR_PROC_CLK_CTRL, 8'h02);
		rd(CCS_ADDR_SUBOSC_MODE, 8'h00);
		rd(CCS_ADDR_SUBCLOCK_SELECT, 8'h00);
		rd(16'hFFF1, 8'h00);
		$display("t_reset done");
	endtask
	task automatic t_clock;
		per(8'h08);
		wr(CCS_ADDR_PROC_CLK_CTRL, 8'h00);
		per(8'h02);
		wr(CCS_ADDR_PROC_CLK_CTRL, 8'h02);
		per(8'h08);
		wr(CCS_ADDR_SUBCLOCK_SELECT, 8'h01, 1, 3'h4);
		rd(CCS_ADDR_SUBCLOCK_SELECT, 8'h10);
		per(8'h10);
		rd(CCS_ADDR_SUBCLOCK_SELECT, 8'h30);
		$display("t_clock done");
	endtask
	task automatic t_stop;
		wr(CCS_ADDR_PROC_CLK_CTRL, 8'h80);
		per(8'h10);
		chk("main_osc_en", 8'(moe), 8'h00);
		clk_cnt(8'h00, 8'h04);
		rd(CCS_ADDR_PROC_CLK_CTRL, 8'h80);
		wr(CCS_ADDR_PROC_CLK_CTRL, 8'h00, 1, 3'h7);
		cyc(3);
		chk("main_osc_en", 8'(moe), 8'h01);
		wr(CCS_ADDR_SUBCLOCK_SELECT, 8'h20);
		cyc(40);
		rd(CCS_ADDR_SUBCLOCK_SELECT, 8'h00);
		@(posedge core_clk);
		stop_mode <= 1;
		cyc(3);
		chk("main_osc_en", 8'(moe), 8'h00);
		chk("sub_osc_en", 8'(soe), 8'h01);
		@(posedge core_clk);
		stop_mode <= 0;
		$display("t_stop done");
	endtask
	task automatic t_sub;
		wr(CCS_ADDR_SUBOSC_MODE, 8'h03);
		cyc(3);
		chk("sub_osc_en", 8'(soe), 8'h00);
		chk("fb_res_en", 8'(fbe), 8'h00);
		clk_cnt(8'h10, 8'h00);
		rd(CCS_ADDR_SUBOSC_MODE, 8'h03);
		$display("t_sub done");
	endtask
	task automatic results;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 0;
		#1;
		chk("main_osc_en", 8'(moe), 8'h00);
		chk("sub_osc_en", 8'(soe), 8'h01);
		chk("fb_res_en", 8'(fbe), 8'h01);
		t_reset;
		t_clock;
		t_stop;
		t_sub;
		results;
	end
	initial begin
		#20000;
		bad_count++;
		results;
	end
endmodule
